// ===== include/spf_pkg.sv
// Shared constants and types for the serial packet framer.
// Functional notes
// - Release buffered bytes after configured idle gap
// - Idle setting zero forwards every byte immediately
// - Transmit spacing accepted from zero to twenty-five
// - Each outgoing byte gets programmed byte-time slot
// - Separator framing caps packets at 512 bytes
// - Match incoming bytes against one-to-four byte separator
// - Close after separator plus zero, one, two bytes
// - No-delay option releases data without coalescing
// - Report and apply control line changes when enabled
package spf_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned FRAME_UNIT_MS = 10;
    localparam int unsigned FRAME_UNIT_CYC = FRAME_UNIT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned FIFO_DEPTH = 32;
    localparam logic [9:0] PKT_LAST_IDX = 10'h1ff;
    localparam logic [4:0] TX_IVL_MAX = 5'h19;
    localparam logic [2:0] SEP_LEN_MAX = 3'h4;
    localparam logic [1:0] SEP_OP_ONLY = 2'h0;
    localparam logic [1:0] SEP_OP_PLUS1 = 2'h1;
    localparam logic [1:0] SEP_OP_PLUS2 = 2'h2;

    typedef struct packed {
        logic last;
        logic [7:0] data;
    } spf_word_s;

    typedef struct packed {
        logic cts;
        logic dsr;
    } spf_lines_s;

    localparam int unsigned WORD_W = $bits(spf_word_s);
endpackage : spf_pkg

// ===== hw/spf_fifo.sv
// Synchronous valid/ready FIFO holding framed bytes.
`timescale 1ns/1ns
module spf_fifo import spf_pkg::*; #(
    parameter int unsigned WIDTH = WORD_W,
    parameter int unsigned DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    logic full;
    logic empty;

    assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    assign empty = (wr_ptr_ff == rd_ptr_ff);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_ff[rd_ptr_ff[AW-1:0]];

    always_ff @(posedge core_clk) begin
        if (in_valid && !full) begin
            mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_ff <= '0;
        end else if (in_valid && !full) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_ptr_ff <= '0;
        end else if (out_ready && !empty) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
        end
    end
endmodule : spf_fifo

// ===== hw/spf_framer.sv
// Serial-to-network packet framer with transmit pacing and control line forwarding.
`timescale 1ns/1ns
module spf_framer import spf_pkg::*; #(
    parameter int unsigned UNIT_CYC = FRAME_UNIT_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Bytes from the serial receiver
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    // Packets toward the network
    output logic net_valid,
    output logic [7:0] net_data,
    output logic net_last,
    input wire logic net_ready,
    // Bytes from the network toward the serial transmitter
    input wire logic tin_valid,
    input wire logic [7:0] tin_data,
    output logic tin_ready,
    output logic sout_valid,
    output logic [7:0] sout_data,
    input wire logic sout_ready,
    // Configuration
    input wire logic [7:0] frame_ivl,
    input wire logic no_delay,
    input wire logic sep_en,
    input wire logic [2:0] sep_len,
    input wire logic [31:0] sep_pat,
    input wire logic [1:0] sep_op,
    input wire logic [4:0] tx_ivl,
    input wire logic [15:0] byte_cycles,
    input wire logic ctl_en,
    // Control lines
    input wire spf_lines_s line_pins,
    output logic line_evt,
    output spf_lines_s line_state,
    input wire logic rmt_valid,
    input wire logic rmt_rts,
    output logic rts_out
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    logic stage_vld_ff;
    logic stage_last_ff;
    logic [7:0] stage_data_ff;
    logic [23:0] hist_ff;
    logic [9:0] blen_ff;
    logic tail_act_ff;
    logic [1:0] tail_ff;
    logic [19:0] tick_ff;
    logic [7:0] unit_ff;
    logic [5:0] pkts_ff;
    logic rx_fire;
    logic timeout;
    logic wr_valid;
    logic wr_ready;
    spf_word_s wr_word;
    spf_word_s rd_word;
    logic rd_valid;
    logic rd_fire;
    logic [9:0] blen_eff;
    logic tail_eff;
    logic [31:0] window;
    logic [31:0] pcat;
    logic [4:1] hit;
    logic match_now;
    logic sep_close;
    logic close_now;

    // Idle timer: counts whole 10 ms units since the most recent byte.
    assign timeout = stage_vld_ff && !stage_last_ff && (frame_ivl != 8'h00) && (unit_ff >= frame_ivl);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_ff <= '0;
            unit_ff <= '0;
        end else if (rx_fire) begin
            tick_ff <= '0;
            unit_ff <= '0;
        end else if (tick_ff == 20'(UNIT_CYC - 1)) begin
            tick_ff <= '0;
            if (unit_ff != 8'hff) begin
                unit_ff <= unit_ff + 8'h01;
            end
        end else begin
            tick_ff <= tick_ff + 20'h00001;
        end
    end

    // The newest byte waits in a stage so its end-of-packet mark can still be set by a later gap.
    assign wr_valid = stage_vld_ff && (stage_last_ff || rx_valid || timeout);
    assign wr_word = '{last: stage_last_ff || timeout, data: stage_data_ff};
    assign rx_ready = !stage_vld_ff || wr_ready;
    assign rx_fire = rx_valid && rx_ready;

    // A gap that ends together with a new byte closes the old packet first.
    assign blen_eff = timeout ? 10'h000 : blen_ff;
    assign tail_eff = tail_act_ff && !timeout;

    assign window = {hist_ff, rx_data};
    assign pcat = {sep_pat[7:0], sep_pat[15:8], sep_pat[23:16], sep_pat[31:24]};

    for (genvar g = 1; g <= 4; g++) begin : g_sep_hit
        assign hit[g] = (window[8*g-1:0] == pcat[31 -: 8*g]);
    end

    always_comb begin
        match_now = 1'b0;
        if (sep_en && (sep_len != 3'h0) && (sep_len <= SEP_LEN_MAX) && ({7'h00, sep_len} <= blen_eff + 10'h001)) begin
            match_now = hit[sep_len];
        end
    end

    assign sep_close = tail_eff ? (tail_ff == 2'h1) : (match_now && (sep_op == SEP_OP_ONLY));
    assign close_now = (frame_ivl == 8'h00) || (sep_en && ((blen_eff == PKT_LAST_IDX) || sep_close));

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage_vld_ff <= 1'b0;
            stage_last_ff <= 1'b0;
            stage_data_ff <= 8'h00;
        end else if (rx_fire) begin
            stage_vld_ff <= 1'b1;
            stage_last_ff <= close_now;
            stage_data_ff <= rx_data;
        end else if (wr_valid && wr_ready) begin
            stage_vld_ff <= 1'b0;
            stage_last_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            blen_ff <= '0;
            hist_ff <= '0;
        end else if (rx_fire) begin
            blen_ff <= close_now ? 10'h000 : blen_eff + 10'h001;
            hist_ff <= window[23:0];
        end else if (timeout) begin
            blen_ff <= '0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tail_act_ff <= 1'b0;
            tail_ff <= '0;
        end else if (rx_fire) begin
            if (close_now) begin
                tail_act_ff <= 1'b0;
            end else if (tail_eff) begin
                tail_ff <= tail_ff - 2'h1;
            end else if (match_now && ((sep_op == SEP_OP_PLUS1) || (sep_op == SEP_OP_PLUS2))) begin
                tail_act_ff <= 1'b1;
                tail_ff <= sep_op;
            end
        end else if (timeout) begin
            tail_act_ff <= 1'b0;
        end
    end

    spf_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .in_valid(wr_valid),
        .in_data(wr_word),
        .in_ready(wr_ready),
        .out_valid(rd_valid),
        .out_data(rd_word),
        .out_ready(net_ready && net_valid)
    );

    // Whole packets are held back unless no-delay is set; a full FIFO also releases, else it would deadlock.
    assign net_valid = rd_valid && (no_delay || (pkts_ff != 6'h00) || !wr_ready);
    assign net_data = rd_word.data;
    assign net_last = rd_word.last;
    assign rd_fire = net_valid && net_ready;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pkts_ff <= '0;
        end else begin
            pkts_ff <= pkts_ff + 6'(wr_valid && wr_ready && wr_word.last) - 6'(rd_fire && rd_word.last);
        end
    end

    // Transmit pacing: each byte owns a slot of tx_ivl byte times, capped at 25, before the next may leave.
    logic [4:0] ivl_eff;
    logic [20:0] gap_ff;
    logic sout_vld_ff;
    logic [7:0] sout_data_ff;

    assign ivl_eff = (tx_ivl > TX_IVL_MAX) ? TX_IVL_MAX : tx_ivl;
    assign tin_ready = !sout_vld_ff && (gap_ff == 21'h000000);
    assign sout_valid = sout_vld_ff;
    assign sout_data = sout_data_ff;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sout_vld_ff <= 1'b0;
            sout_data_ff <= 8'h00;
        end else if (tin_valid && tin_ready) begin
            sout_vld_ff <= 1'b1;
            sout_data_ff <= tin_data;
        end else if (sout_ready) begin
            sout_vld_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            gap_ff <= '0;
        end else if (sout_vld_ff && sout_ready) begin
            gap_ff <= 21'(ivl_eff) * 21'(byte_cycles);
        end else if (gap_ff != 21'h000000) begin
            gap_ff <= gap_ff - 21'h000001;
        end
    end

    // Control lines arrive from pins and pass two flip-flops before use.
    spf_lines_s ln_s1_ff;
    spf_lines_s ln_s2_ff;
    spf_lines_s ln_prev_ff;
    logic evt_ff;
    spf_lines_s state_ff;
    logic rts_ff;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ln_s1_ff <= '0;
            ln_s2_ff <= '0;
            ln_prev_ff <= '0;
        end else begin
            ln_s1_ff <= line_pins;
            ln_s2_ff <= ln_s1_ff;
            ln_prev_ff <= ln_s2_ff;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            evt_ff <= 1'b0;
            state_ff <= '0;
        end else begin
            evt_ff <= ctl_en && (ln_s2_ff != ln_prev_ff);
            state_ff <= ln_s2_ff;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rts_ff <= 1'b0;
        end else if (ctl_en && rmt_valid) begin
            rts_ff <= rmt_rts;
        end
    end

    assign line_evt = evt_ff;
    assign line_state = state_ff;
    assign rts_out = rts_ff;

    a_idle_gap_close: assert property (timeout && wr_ready && !rx_valid |=> !stage_vld_ff && pkts_ff != 6'h00)
        else $error("Idle gap did not close the staged byte.");
    a_zero_ivl_each: assert property (rx_fire && frame_ivl == 8'h00 |=> stage_vld_ff && stage_last_ff)
        else $error("Zero idle setting did not close each byte.");
    a_timer_restart: assert property (rx_fire |=> unit_ff == 8'h00 && tick_ff == 20'h00000)
        else $error("Received byte did not restart the idle timer.");
    a_pkt_cap_len: assert property (rx_fire && sep_en && blen_eff == PKT_LAST_IDX |=> stage_last_ff)
        else $error("Packet exceeded the separator-mode size cap.");
    a_sep_plain_hit: assert property (rx_fire && match_now && !tail_eff && sep_op == SEP_OP_ONLY |=> stage_last_ff)
        else $error("Separator match did not close the packet.");
    a_sep_tail_end: assert property (rx_fire && tail_eff && tail_ff == 2'h1 |=> stage_last_ff && !tail_act_ff)
        else $error("Separator trailer did not end the packet.");
    a_no_delay_pass: assert property (no_delay && rd_valid |-> net_valid)
        else $error("No-delay data was held back.");
    a_tx_slot_hold: assert property (sout_vld_ff && sout_ready && ivl_eff != 5'h00 && byte_cycles != 16'h0000
        && (ivl_eff > 5'h01 || byte_cycles > 16'h0001) |=> !tin_ready [*2])
        else $error("Next outgoing byte accepted inside its slot.");
    a_tx_ivl_range: assert property (sout_vld_ff && sout_ready |=> gap_ff <= 21'(TX_IVL_MAX) * 21'(byte_cycles))
        else $error("Transmit spacing exceeded its range.");
    a_line_report: assert property (ctl_en && ln_s2_ff != ln_prev_ff |=> line_evt && line_state == $past(ln_s2_ff))
        else $error("Control line change was not reported.");
endmodule : spf_framer

// ===== verif/spf_serial_model.sv
// Behavioural serial device that takes paced bytes from the framer's transmit side.
`timescale 1ns/1ns
module spf_serial_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Bytes from the framer
    input wire logic sout_valid,
    input wire logic [7:0] sout_data,
    output logic sout_ready,
    // Bench control and observation
    input wire logic stall,
    output logic [7:0] last_byte,
    output int n_got
);
    // A device without a buffer refuses bytes while busy, so stall simply drops ready.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sout_ready <= 1'b0;
            last_byte <= 8'h00;
            n_got <= 0;
        end else begin
            sout_ready <= !stall;
            if (sout_valid && sout_ready) begin
                last_byte <= sout_data;
                n_got <= n_got + 1;
            end
        end
    end
endmodule : spf_serial_model

// ===== verif/tb_serial_packet_framer.sv
// Self-checking bench for the serial packet framer.
`timescale 1ns/1ns
module tb_serial_packet_framer import spf_pkg::*; ();
    localparam int U = 4;
    typedef struct packed {
        logic [7:0] ivl;
        logic en;
        logic [2:0] len;
        logic [1:0] op;
        logic [3:0] first;
        logic [3:0] n;
    } spf_row_s;
    logic core_clk = 1'b0, reset_n = 1'b0, rx_valid = 1'b0, net_ready = 1'b1, tin_valid = 1'b0;
    logic no_delay = 1'b0, sep_en = 1'b0, ctl_en = 1'b0, rmt_valid = 1'b0, rmt_rts = 1'b0, stall = 1'b0;
    logic [7:0] rx_data = 8'hff, tin_data = 8'h00, frame_ivl = 8'h00;
    logic [2:0] sep_len = 3'h0;
    logic [1:0] sep_op = 2'h0;
    logic [4:0] tx_ivl = 5'h00;
    logic [31:0] sep_pat = 32'h00000a0d;
    logic [15:0] byte_cycles = 16'h0004;
    spf_lines_s line_pins = 2'b00;
    logic rx_ready, net_valid, net_last, tin_ready, sout_valid, sout_ready, line_evt, rts_out;
    logic [7:0] net_data, sout_data, last_byte;
    spf_lines_s line_state;
    int n_got, n_errors = 0, comparisons = 0, cyc = 0;
    logic [7:0] got_d[$];
    logic got_l[$];
    logic [7:0] seq[6] = '{8'h10, 8'h11, 8'h0d, 8'h0a, 8'h14, 8'h15};
    // Columns: idle units, separator on, length, operation, first end index, end count.
    spf_row_s rows[7] = '{
        '{8'h00, 1'b0, 3'h0, 2'h0, 4'h0, 4'h6},
        '{8'h0b, 1'b0, 3'h0, 2'h0, 4'h5, 4'h1},
        '{8'h0b, 1'b1, 3'h2, 2'h0, 4'h3, 4'h2},
        '{8'h0b, 1'b1, 3'h2, 2'h1, 4'h4, 4'h2},
        '{8'h0b, 1'b1, 3'h2, 2'h2, 4'h5, 4'h1},
        '{8'h0b, 1'b1, 3'h2, 2'h3, 4'h5, 4'h1},
        '{8'h0b, 1'b1, 3'h0, 2'h0, 4'h5, 4'h1}
    };
    spf_framer #(.UNIT_CYC(U)) i_spf_framer (.core_clk(core_clk), .reset_n(reset_n),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .net_valid(net_valid),
        .net_data(net_data), .net_last(net_last), .net_ready(net_ready), .tin_valid(tin_valid),
        .tin_data(tin_data), .tin_ready(tin_ready), .sout_valid(sout_valid), .sout_data(sout_data),
        .sout_ready(sout_ready), .frame_ivl(frame_ivl), .no_delay(no_delay), .sep_en(sep_en),
        .sep_len(sep_len), .sep_pat(sep_pat), .sep_op(sep_op), .tx_ivl(tx_ivl), .byte_cycles(byte_cycles),
        .ctl_en(ctl_en), .line_pins(line_pins), .line_evt(line_evt), .line_state(line_state),
        .rmt_valid(rmt_valid), .rmt_rts(rmt_rts), .rts_out(rts_out));
    spf_serial_model i_spf_serial_model (.core_clk(core_clk), .reset_n(reset_n), .sout_valid(sout_valid),
        .sout_data(sout_data), .sout_ready(sout_ready), .stall(stall), .last_byte(last_byte), .n_got(n_got));
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            n_errors++;
            final_report();
        end
    end
    // Words are logged half a cycle before the popping edge, when valid and ready are settled.
    always @(negedge core_clk) begin
        if (net_valid === 1'b1 && net_ready === 1'b1) begin
            got_d.push_back(net_data);
            got_l.push_back(net_last);
        end
    end
    task automatic final_report();
        if (n_errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_cyc
    // Valid stays up between calls so bytes go back to back; rx_end releases it.
    task automatic rx(input logic [7:0] b, output bit ok);
        int k;
        rx_data = b;
        rx_valid = 1'b1;
        ok = 1'b0;
        for (k = 0; k < 40 && !ok; k++) begin
            @(negedge core_clk);
            ok = (rx_ready === 1'b1);
        end
        wait_cyc(1);
    endtask : rx
    task automatic rx_end();
        rx_valid = 1'b0;
        rx_data = ~rx_data;
    endtask : rx_end
    task automatic cfg(input logic [7:0] i, input logic e, input logic [2:0] l, input logic [1:0] o);
        frame_ivl = i;
        sep_en = e;
        sep_len = l;
        sep_op = o;
        got_d.delete();
        got_l.delete();
    endtask : cfg
    function automatic int first_last();
        foreach (got_l[q]) if (got_l[q] === 1'b1) return q;
        return -1;
    endfunction : first_last
    function automatic int n_last();
        n_last = 0;
        foreach (got_l[q]) n_last += (got_l[q] === 1'b1);
    endfunction : n_last
    initial begin
        int i, k, g, n;
        bit ok;
        logic [4:0] ivls[4];
        ivls = '{5'h00, 5'h05, 5'h19, 5'h1f};
        #26;
        check("reset outputs", 32'ha0, 32'({rx_ready, net_valid, tin_ready, sout_valid, line_evt, line_state, rts_out}));
        #20;
        reset_n = 1'b1;
        foreach (rows[r]) begin
            cfg(rows[r].ivl, rows[r].en, rows[r].len, rows[r].op);
            for (i = 0; i < 6; i++) rx(seq[i], ok);
            rx_end();
            wait_cyc(80);
            check("row words", 6, got_d.size());
            check("row first end", rows[r].first, first_last());
            check("row ends", rows[r].n, n_last());
            foreach (seq[q]) check("row data", seq[q], got_d[q]);
        end
        cfg(8'h0b, 1'b0, 3'h0, 2'h0);
        rx(8'h21, ok);
        rx_end();
        wait_cyc(30);
        check("early release", 0, got_d.size());
        rx(8'h22, ok);
        rx_end();
        for (k = 0; k < 200 && got_d.size() == 0; k++) wait_cyc(1);
        check("idle release", 1, k >= 11 * U - 4 && k <= 11 * U + 8);
        wait_cyc(4);
        check("gap packet end", 1, first_last());
        cfg(8'h0b, 1'b0, 3'h0, 2'h0);
        no_delay = 1'b1;
        rx(8'h31, ok);
        rx(8'h32, ok);
        rx_end();
        wait_cyc(4);
        check("early words", 1, got_d.size());
        wait_cyc(60);
        no_delay = 1'b0;
        cfg(8'h0b, 1'b1, 3'h0, 2'h0);
        for (i = 0; i < 513; i++) rx(8'(i), ok);
        rx_end();
        wait_cyc(80);
        check("cap words", 513, got_d.size());
        check("cap end", 511, first_last());
        check("cap ends", 2, n_last());
        cfg(8'h00, 1'b0, 3'h0, 2'h0);
        net_ready = 1'b0;
        n = 0;
        ok = 1'b1;
        for (i = 0; i < 40 && ok; i++) begin
            rx(8'(i), ok);
            n += ok;
        end
        rx_end();
        check("fill count", FIFO_DEPTH + 1, n);
        check("held words", 0, got_d.size());
        net_ready = 1'b1;
        wait_cyc(60);
        check("drain ends", FIFO_DEPTH + 1, n_last());
        foreach (ivls[v]) begin
            tx_ivl = ivls[v];
            stall = 1'b1;
            tin_data = 8'h40 + 8'(v);
            tin_valid = 1'b1;
            k = 0;
            do @(negedge core_clk); while (tin_ready !== 1'b1 && ++k < 400);
            wait_cyc(1);
            tin_valid = 1'b0;
            wait_cyc(3);
            check("sout stands", {1'b1, tin_data}, 32'({sout_valid, sout_data}));
            stall = 1'b0;
            do @(negedge core_clk); while (sout_ready !== 1'b1 && ++k < 400);
            g = 0;
            @(negedge core_clk);
            while (tin_ready === 1'b0 && g < 400) begin
                g++;
                @(negedge core_clk);
            end
            check("tx gap", (ivls[v] > TX_IVL_MAX ? TX_IVL_MAX : ivls[v]) * byte_cycles, g);
            check("tx byte", tin_data, last_byte);
            wait_cyc(1);
        end
        ctl_en = 1'b1;
        line_pins = 2'b10;
        k = 0;
        do @(negedge core_clk); while (line_evt !== 1'b1 && ++k < 8);
        check("event delay", 3, k);
        check("line state", 2'b10, line_state);
        @(negedge core_clk);
        check("event pulse", 0, line_evt);
        wait_cyc(1);
        ctl_en = 1'b0;
        line_pins = 2'b11;
        rmt_rts = 1'b1;
        rmt_valid = 1'b1;
        wait_cyc(1);
        rmt_valid = 1'b0;
        k = 0;
        repeat (6) begin
            @(negedge core_clk);
            k += (line_evt === 1'b1);
        end
        check("masked events", 0, k);
        check("rts held", 0, rts_out);
        wait_cyc(1);
        ctl_en = 1'b1;
        rmt_valid = 1'b1;
        wait_cyc(1);
        rmt_valid = 1'b0;
        check("rts applied", 1, rts_out);
        final_report();
    end
endmodule : tb_serial_packet_framer
